/* File: src/lpsdc_pkg.sv */
// constants for the panel sequence and dstn line pulse control block
// assumes an 8-bit indexed register port and a single ref_clk domain
package lpsdc_pkg;
    // register indices behind the data port
    localparam logic [7:0] IDX_SEQ_LP = 8'h34;
    localparam logic [7:0] IDX_HEIGHT_HI = 8'h3E;
    localparam logic [7:0] IDX_HEIGHT_LO = 8'h3F;
    localparam logic [7:0] IDX_F1_LO = 8'h40;
    localparam logic [7:0] IDX_F1_HI = 8'h41;
    localparam logic [7:0] IDX_F2_LO = 8'h42;
    // values after reset
    localparam logic [7:0] RST_SEQ_LP = 8'h80;
    localparam logic [7:0] RST_HEIGHT = 8'h00;
    localparam logic [7:0] RST_INDEX = 8'h00;
    // field positions, sequence and line pulse register
    localparam int SEQ_HW_BIT = 7;
    localparam int SEQ_WIDE_BIT = 6;
    localparam int SEQ_ODD_LSB = 4;
    localparam int SEQ_EVEN_LSB = 0;
    // field positions, height high register
    localparam int HH_MSIG_BIT = 7;
    localparam int HH_GFX_BIT = 5;
    localparam int HH_VID_BIT = 4;
    localparam int HH_FDET_BIT = 3;
    localparam int HH_FREE_BIT = 2;
    // line pulse widths in pixel clocks
    localparam logic [5:0] LP_WIDTH_NARROW = 6'h10;
    localparam logic [5:0] LP_WIDTH_WIDE = 6'h20;
    // power steps in order of switching on
    localparam logic [2:0] PWR_LEVEL_FULL = 3'h4;
    typedef enum logic {LPSDC_LP_IDLE, LPSDC_LP_ACTIVE} lpsdc_lp_state_t;
endpackage

/* File: src/lpsdc_pwr_seq.sv */
// hardware panel power on/off sequencer
// assumes frame_tick is a one-cycle pulse per vertical frame on ref_clk
`timescale 1ns/1ps
`default_nettype none
module lpsdc_pwr_seq
    import lpsdc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic power_on_req,
    input wire logic frame_tick,
    input wire logic [1:0] step_code,
    output logic [2:0] level
);
    logic [2:0] level_r, level_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [3:0] interval;

    ////////////////////////////////////////////////////////////////////////
    // step spacing 1, 2, 4 or 8 frames
    always_comb begin
        interval = 4'h1 << step_code;
        level_nxt = level_r;
        cnt_nxt = 4'h0;
        if ((power_on_req && level_r != PWR_LEVEL_FULL) || (!power_on_req && level_r != 3'h0)) begin
            cnt_nxt = cnt_r;
            if (frame_tick) begin
                if (cnt_r + 4'h1 == interval) begin
                    cnt_nxt = 4'h0;
                    level_nxt = power_on_req ? level_r + 3'h1 : level_r - 3'h1;
                end else begin
                    cnt_nxt = cnt_r + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            level_r <= 3'h0;
            cnt_r <= 4'h0;
        end else begin
            level_r <= level_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign level = level_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_step_on_frame;
        @(posedge ref_clk) disable iff (!resetn)
        (level_r != $past(level_r)) |-> $past(frame_tick);
    endproperty
    a_step_on_frame: assert property (p_step_on_frame)
        else $error("power step without frame tick");
endmodule
`default_nettype wire

/* File: src/lpsdc_ctrl.sv */
// panel sequence select, dstn line pulse, panel height and read fifo start
// assumes io_* , hsync_start, vsync_start, display_enable_in, sw_power_ctrl,
// dstn_select, virtual_refresh_enable and step_code come from ref_clk logic;
// frame_pulse_pin is asynchronous and is synchronised here
// Overview of operation
// - bit 7 set: hardware power sequencer drives panel power; clear: software drives
// - dstn line pulse lasts 16 pixel clocks, or 32 when width bit set
// - standard refresh dstn: odd frames get 0 to 3 extra line pulses
// - four-bit field adds pulses to even frames, or every frame in virtual refresh
// - sequence and line pulse register reads 80h after reset
// - panel height is high bits 1:0 over the full low register
// - shared panel pin carries display enable, or alternating drive when bit set
// - graphics flip bit set by software, cleared by device after flipping
// - video flip bit set by software, cleared by device after flipping
// - frame pulse detect bit set by software, cleared once pulse seen
// - free running enable keeps line pulses coming continuously
// - read fifo1 start address is high register over low register
// - virtual refresh with dstn: fifo1 start serves the upper panel
// - fifo2 start low serves the lower panel, valid only for virtual dstn
// - height registers reset to 00h; fifo start registers keep no reset
// - step timing matters only while hardware sequencing is selected
// - hardware steps are spaced 1, 2, 4 or 8 frames
// - dual panel split needs both the virtual refresh enable and dstn select
`timescale 1ns/1ps
`default_nettype none
module lpsdc_ctrl
    import lpsdc_pkg::*;
#(
    parameter int LINE_PERIOD = 800
)(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic io_write,
    input wire logic io_read,
    input wire logic io_port_sel,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic hsync_start,
    input wire logic vsync_start,
    input wire logic display_enable_in,
    input wire logic frame_pulse_pin,
    input wire logic dstn_select,
    input wire logic virtual_refresh_enable,
    input wire logic [1:0] step_code,
    input wire logic power_on_req,
    input wire logic [3:0] sw_power_ctrl,
    output logic line_pulse,
    output logic panel_mux_out,
    output logic panel_enable_out,
    output logic bias_enable_out,
    output logic panel_ctrl_enable_out,
    output logic panel_supply_enable_out,
    output logic graphics_flip_pulse,
    output logic video_flip_pulse,
    output logic [9:0] panel_height,
    output logic [15:0] fifo1_start_addr,
    output logic [7:0] fifo2_start_low,
    output logic dual_panel_split
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    // register port
    logic [7:0] index_r, index_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] seq_r, seq_nxt;
    logic msig_sel_r, msig_sel_nxt;
    logic free_run_r, free_run_nxt;
    logic [1:0] height_hi_r, height_hi_nxt;
    logic [7:0] height_lo_r, height_lo_nxt;
    logic gfx_req_r, gfx_req_nxt;
    logic vid_req_r, vid_req_nxt;
    logic fdet_req_r, fdet_req_nxt;
    logic gfx_pulse_r, gfx_pulse_nxt;
    logic vid_pulse_r, vid_pulse_nxt;
    logic [7:0] f1_lo_r, f1_lo_nxt;
    logic [7:0] f1_hi_r, f1_hi_nxt;
    logic [7:0] f2_lo_r, f2_lo_nxt;
    logic wr_data;
    logic fp_edge;

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        hit = (idx == want);
    endfunction

    always_comb begin
        wr_data = io_write && io_port_sel;
        index_nxt = (io_write && !io_port_sel) ? io_wdata : index_r;
        seq_nxt = seq_r;
        msig_sel_nxt = msig_sel_r;
        free_run_nxt = free_run_r;
        height_hi_nxt = height_hi_r;
        height_lo_nxt = height_lo_r;
        f1_lo_nxt = f1_lo_r;
        f1_hi_nxt = f1_hi_r;
        f2_lo_nxt = f2_lo_r;
        // requests clear on completion, a software set wins the same cycle
        gfx_req_nxt = gfx_req_r && !vsync_start;
        vid_req_nxt = vid_req_r && !vsync_start;
        fdet_req_nxt = fdet_req_r && !fp_edge;
        gfx_pulse_nxt = gfx_req_r && vsync_start;
        vid_pulse_nxt = vid_req_r && vsync_start;
        if (wr_data) begin
            if (hit(index_r, IDX_SEQ_LP)) begin
                seq_nxt = io_wdata;
            end
            if (hit(index_r, IDX_HEIGHT_HI)) begin
                msig_sel_nxt = io_wdata[HH_MSIG_BIT];
                free_run_nxt = io_wdata[HH_FREE_BIT];
                height_hi_nxt = io_wdata[1:0];
                // only ones take effect on request bits
                if (io_wdata[HH_GFX_BIT]) gfx_req_nxt = 1'b1;
                if (io_wdata[HH_VID_BIT]) vid_req_nxt = 1'b1;
                if (io_wdata[HH_FDET_BIT]) fdet_req_nxt = 1'b1;
            end
            if (hit(index_r, IDX_HEIGHT_LO)) height_lo_nxt = io_wdata;
            if (hit(index_r, IDX_F1_LO)) f1_lo_nxt = io_wdata;
            if (hit(index_r, IDX_F1_HI)) f1_hi_nxt = io_wdata;
            if (hit(index_r, IDX_F2_LO)) f2_lo_nxt = io_wdata;
        end
        rdata_nxt = rdata_r;
        if (io_read) begin
            if (!io_port_sel) begin
                rdata_nxt = index_r;
            end else if (hit(index_r, IDX_SEQ_LP)) begin
                rdata_nxt = seq_r;
            end else if (hit(index_r, IDX_HEIGHT_HI)) begin
                rdata_nxt = {msig_sel_r, 1'b0, gfx_req_r, vid_req_r, fdet_req_r,
                             free_run_r, height_hi_r};
            end else if (hit(index_r, IDX_HEIGHT_LO)) begin
                rdata_nxt = height_lo_r;
            end else if (hit(index_r, IDX_F1_LO)) begin
                rdata_nxt = f1_lo_r;
            end else if (hit(index_r, IDX_F1_HI)) begin
                rdata_nxt = f1_hi_r;
            end else if (hit(index_r, IDX_F2_LO)) begin
                rdata_nxt = f2_lo_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            index_r <= RST_INDEX;
            rdata_r <= 8'h00;
            seq_r <= RST_SEQ_LP;
            msig_sel_r <= 1'b0;
            free_run_r <= 1'b0;
            height_hi_r <= RST_HEIGHT[1:0];
            height_lo_r <= RST_HEIGHT;
            gfx_req_r <= 1'b0;
            vid_req_r <= 1'b0;
            fdet_req_r <= 1'b0;
            gfx_pulse_r <= 1'b0;
            vid_pulse_r <= 1'b0;
        end else begin
            index_r <= index_nxt;
            rdata_r <= rdata_nxt;
            seq_r <= seq_nxt;
            msig_sel_r <= msig_sel_nxt;
            free_run_r <= free_run_nxt;
            height_hi_r <= height_hi_nxt;
            height_lo_r <= height_lo_nxt;
            gfx_req_r <= gfx_req_nxt;
            vid_req_r <= vid_req_nxt;
            fdet_req_r <= fdet_req_nxt;
            gfx_pulse_r <= gfx_pulse_nxt;
            vid_pulse_r <= vid_pulse_nxt;
        end
    end

    // fifo start registers power up undefined
    always_ff @(posedge ref_clk) begin
        f1_lo_r <= f1_lo_nxt;
        f1_hi_r <= f1_hi_nxt;
        f2_lo_r <= f2_lo_nxt;
    end

    assign io_rdata = rdata_r;
    assign graphics_flip_pulse = gfx_pulse_r;
    assign video_flip_pulse = vid_pulse_r;
    assign panel_height = {height_hi_r, height_lo_r};
    assign fifo1_start_addr = {f1_hi_r, f1_lo_r};
    assign fifo2_start_low = f2_lo_r;

    ////////////////////////////////////////////////////////////////////////
    // frame pulse pin synchroniser
    logic fp_meta_r, fp_sync_r, fp_prev_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fp_meta_r <= 1'b0;
            fp_sync_r <= 1'b0;
            fp_prev_r <= 1'b0;
        end else begin
            fp_meta_r <= frame_pulse_pin;
            fp_sync_r <= fp_meta_r;
            fp_prev_r <= fp_sync_r;
        end
    end

    assign fp_edge = fp_sync_r && !fp_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // frame parity, mux pin, split mode, power outputs
    logic odd_frame_r, odd_frame_nxt;
    logic mux_r, mux_nxt;
    logic split_r, split_nxt;
    logic [3:0] pwr_r, pwr_nxt;
    logic [2:0] seq_level;

    lpsdc_pwr_seq u_pwr_seq (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .power_on_req(power_on_req),
        .frame_tick(vsync_start),
        .step_code(step_code),
        .level(seq_level)
    );

    always_comb begin
        odd_frame_nxt = vsync_start ? !odd_frame_r : odd_frame_r;
        // alternating drive follows frame parity
        mux_nxt = msig_sel_r ? odd_frame_r : display_enable_in;
        split_nxt = virtual_refresh_enable && dstn_select;
        if (seq_r[SEQ_HW_BIT]) begin
            // steps: panel enable, bias, control signals, supply
            pwr_nxt = {seq_level >= 3'h4, seq_level >= 3'h3,
                       seq_level >= 3'h2, seq_level >= 3'h1};
        end else begin
            pwr_nxt = sw_power_ctrl;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            odd_frame_r <= 1'b1;
            mux_r <= 1'b0;
            split_r <= 1'b0;
            pwr_r <= 4'h0;
        end else begin
            odd_frame_r <= odd_frame_nxt;
            mux_r <= mux_nxt;
            split_r <= split_nxt;
            pwr_r <= pwr_nxt;
        end
    end

    assign panel_mux_out = mux_r;
    assign dual_panel_split = split_r;
    assign panel_enable_out = pwr_r[0];
    assign bias_enable_out = pwr_r[1];
    assign panel_ctrl_enable_out = pwr_r[2];
    assign panel_supply_enable_out = pwr_r[3];

    ////////////////////////////////////////////////////////////////////////
    // line pulse generator
    lpsdc_lp_state_t lp_state_r, lp_state_nxt;
    logic [5:0] lp_cnt_r, lp_cnt_nxt;
    logic lp_wide_r, lp_wide_nxt;
    logic [3:0] pend_r, pend_nxt;
    logic [15:0] fr_cnt_r, fr_cnt_nxt;
    logic fr_fire;
    logic lp_start;

    always_comb begin
        fr_fire = free_run_r && (fr_cnt_r == 16'(LINE_PERIOD - 1));
        fr_cnt_nxt = (!free_run_r || fr_fire) ? 16'h0000 : fr_cnt_r + 16'h0001;
        lp_start = (lp_state_r == LPSDC_LP_IDLE) &&
                   (hsync_start || fr_fire || pend_r != 4'h0);
        lp_state_nxt = lp_state_r;
        lp_cnt_nxt = lp_cnt_r;
        lp_wide_nxt = lp_wide_r;
        pend_nxt = pend_r;
        if (lp_start && !hsync_start && !fr_fire) begin
            pend_nxt = pend_r - 4'h1;
        end
        if (vsync_start && dstn_select) begin
            if (virtual_refresh_enable || !odd_frame_r) begin
                pend_nxt = seq_r[SEQ_EVEN_LSB +: 4];
            end else begin
                pend_nxt = {2'b00, seq_r[SEQ_ODD_LSB +: 2]};
            end
        end
        unique case (lp_state_r)
            LPSDC_LP_IDLE: begin
                if (lp_start) begin
                    lp_state_nxt = LPSDC_LP_ACTIVE;
                    lp_cnt_nxt = 6'h01;
                    lp_wide_nxt = seq_r[SEQ_WIDE_BIT];
                end
            end
            LPSDC_LP_ACTIVE: begin
                if (lp_cnt_r == (lp_wide_r ? LP_WIDTH_WIDE : LP_WIDTH_NARROW)) begin
                    lp_state_nxt = LPSDC_LP_IDLE;
                end else begin
                    lp_cnt_nxt = lp_cnt_r + 6'h01;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lp_state_r <= LPSDC_LP_IDLE;
            lp_cnt_r <= 6'h00;
            lp_wide_r <= 1'b0;
            pend_r <= 4'h0;
            fr_cnt_r <= 16'h0000;
        end else begin
            lp_state_r <= lp_state_nxt;
            lp_cnt_r <= lp_cnt_nxt;
            lp_wide_r <= lp_wide_nxt;
            pend_r <= pend_nxt;
            fr_cnt_r <= fr_cnt_nxt;
        end
    end

    assign line_pulse = (lp_state_r == LPSDC_LP_ACTIVE);

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic hh_write;
    assign hh_write = wr_data && hit(index_r, IDX_HEIGHT_HI);

    property p_lp_width;
        $fell(line_pulse) |-> $past(lp_cnt_r) == (lp_wide_r ? 6'h20 : 6'h10);
    endproperty
    a_lp_width: assert property (p_lp_width)
        else $error("line pulse width wrong");

    property p_odd_extra;
        (vsync_start && dstn_select && !virtual_refresh_enable && odd_frame_r)
            |=> pend_r == {2'b00, $past(seq_r[5:4])};
    endproperty
    a_odd_extra: assert property (p_odd_extra)
        else $error("odd frame extra count not loaded");

    property p_every_extra;
        (vsync_start && dstn_select && virtual_refresh_enable)
            |=> pend_r == $past(seq_r[3:0]);
    endproperty
    a_every_extra: assert property (p_every_extra)
        else $error("extra line pulse count not loaded");

    property p_mux_pin;
        1'b1 |=> panel_mux_out == ($past(msig_sel_r) ? $past(odd_frame_r)
                                                      : $past(display_enable_in));
    endproperty
    a_mux_pin: assert property (p_mux_pin)
        else $error("panel mux pin wrong source");

    property p_gfx_done;
        (gfx_req_r && vsync_start && !hh_write) |=> !gfx_req_r && graphics_flip_pulse;
    endproperty
    a_gfx_done: assert property (p_gfx_done)
        else $error("graphics flip not completed");

    property p_vid_done;
        (vid_req_r && vsync_start && !hh_write)
            |=> !vid_req_r && video_flip_pulse ##1 !video_flip_pulse;
    endproperty
    a_vid_done: assert property (p_vid_done)
        else $error("video flip not completed");

    property p_fdet_done;
        (fdet_req_r && fp_edge && !hh_write) |=> !fdet_req_r;
    endproperty
    a_fdet_done: assert property (p_fdet_done)
        else $error("frame pulse request not cleared");

    property p_zero_write;
        (hh_write && !io_wdata[5] && gfx_req_r && !vsync_start) |=> gfx_req_r;
    endproperty
    a_zero_write: assert property (p_zero_write)
        else $error("zero write cleared request");

    property p_free_run;
        (fr_fire && lp_state_r == LPSDC_LP_IDLE) |=> line_pulse [*2];
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("free running pulse missing");

    property p_sw_power;
        !seq_r[7] |=> {panel_supply_enable_out, panel_ctrl_enable_out, bias_enable_out,
                       panel_enable_out} == $past(sw_power_ctrl);
    endproperty
    a_sw_power: assert property (p_sw_power)
        else $error("software power control not followed");

    c_gfx_flip: cover property (gfx_req_r ##[1:1000] graphics_flip_pulse);
    c_wide_pulse: cover property ($fell(line_pulse) && lp_wide_r);
    c_odd_extra: cover property (pend_r == 4'h3 ##1 line_pulse);
    c_hw_power: cover property (seq_level == PWR_LEVEL_FULL && panel_supply_enable_out);
endmodule
`default_nettype wire

/* File: dv/lpsdc_panel_model.sv */
// panel side model: measures line pulses, drives the frame pulse pin
// assumes the bench raises fp_req as a level for a few cycles
`timescale 1ns/1ps
`default_nettype none
module lpsdc_panel_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic line_pulse,
    input wire logic fp_req,
    output var logic frame_pulse_pin,
    output int n_lp,
    output int last_w
);
    int w;
    ////////////////////////////////////////
    // pulse width and count, pixel clocks
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            n_lp <= 0;
            w <= 0;
            last_w <= 0;
        end else if (line_pulse === 1'b1) begin
            w <= w + 1;
        end else if (w != 0) begin
            n_lp <= n_lp + 1;
            last_w <= w;
            w <= 0;
        end
    end
    ////////////////////////////////////////
    // frame pulse pin, idles low
    always @(negedge ref_clk or negedge resetn) begin
        if (!resetn) frame_pulse_pin <= 1'b0;
        else frame_pulse_pin <= fp_req;
    end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// bench for the panel sequence and line pulse block
// assumes the panel model file and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import lpsdc_pkg::*;
;
    logic ref_clk, resetn, io_write, io_read, io_port_sel, hsync_start, vsync_start, fp_req;
    logic display_enable_in, frame_pulse_pin, dstn_select, virtual_refresh_enable, power_on_req;
    logic line_pulse, panel_mux_out, panel_enable_out, bias_enable_out, panel_ctrl_enable_out;
    logic panel_supply_enable_out, graphics_flip_pulse, video_flip_pulse, dual_panel_split, par;
    logic [7:0] io_wdata, io_rdata, fifo2_start_low, e;
    logic [1:0] step_code;
    logic [3:0] sw_power_ctrl;
    logic [9:0] panel_height;
    logic [15:0] fifo1_start_addr;
    logic [7:0] mdl [256];
    logic [31:0] seed, r;
    int n_mismatch, checks, n_lp, last_w, n_gf, n_vf, k, c, n0;
    wire [3:0] pwr = {panel_supply_enable_out, panel_ctrl_enable_out, bias_enable_out,
        panel_enable_out};
    ////////////////////////////////////////
    lpsdc_ctrl #(.LINE_PERIOD(40)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
        .io_write(io_write), .io_read(io_read), .io_port_sel(io_port_sel),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .hsync_start(hsync_start),
        .vsync_start(vsync_start), .display_enable_in(display_enable_in),
        .frame_pulse_pin(frame_pulse_pin), .dstn_select(dstn_select),
        .virtual_refresh_enable(virtual_refresh_enable), .step_code(step_code),
        .power_on_req(power_on_req), .sw_power_ctrl(sw_power_ctrl), .line_pulse(line_pulse),
        .panel_mux_out(panel_mux_out), .panel_enable_out(panel_enable_out),
        .bias_enable_out(bias_enable_out), .panel_ctrl_enable_out(panel_ctrl_enable_out),
        .panel_supply_enable_out(panel_supply_enable_out),
        .graphics_flip_pulse(graphics_flip_pulse), .video_flip_pulse(video_flip_pulse),
        .panel_height(panel_height), .fifo1_start_addr(fifo1_start_addr),
        .fifo2_start_low(fifo2_start_low), .dual_panel_split(dual_panel_split));
    lpsdc_panel_model u_panel (.ref_clk(ref_clk), .resetn(resetn), .line_pulse(line_pulse),
        .fp_req(fp_req), .frame_pulse_pin(frame_pulse_pin), .n_lp(n_lp), .last_w(last_w));
    ////////////////////////////////////////
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (graphics_flip_pulse === 1'b1) n_gf++;
        if (video_flip_pulse === 1'b1) n_vf++;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // indexed port accesses, register model kept in mdl
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {io_write, io_port_sel, io_wdata} = {2'b10, a};
        @(negedge ref_clk);
        {io_port_sel, io_wdata} = {1'b1, d};
        @(negedge ref_clk);
        io_write = 1'b0;
        if (a == IDX_HEIGHT_HI) mdl[a] = {d[7], 1'b0, mdl[a][5:3] | d[5:3], d[2:0]};
        else if (a inside {IDX_SEQ_LP, IDX_HEIGHT_LO, IDX_F1_LO, IDX_F1_HI, IDX_F2_LO}) mdl[a] = d;
    endtask
    task automatic rdc(input logic [7:0] a);
        @(negedge ref_clk);
        {io_write, io_port_sel, io_wdata} = {2'b10, a};
        @(negedge ref_clk);
        {io_write, io_read, io_port_sel} = 3'b011;
        @(negedge ref_clk);
        io_read = 1'b0;
        chk(io_rdata, mdl[a]);
    endtask
    task automatic vs();
        @(negedge ref_clk);
        vsync_start = 1'b1;
        @(negedge ref_clk);
        vsync_start = 1'b0;
        par = ~par;
        mdl[IDX_HEIGHT_HI][5:4] = 2'b00;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic hs();
        @(negedge ref_clk);
        hsync_start = 1'b1;
        @(negedge ref_clk);
        hsync_start = 1'b0;
    endtask
    ////////////////////////////////////////
    initial begin
        #5000000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {ref_clk, resetn, io_write, io_read, io_port_sel, hsync_start, vsync_start} = '0;
        {display_enable_in, fp_req, dstn_select, virtual_refresh_enable, power_on_req} = '0;
        {io_wdata, step_code, sw_power_ctrl} = '0;
        {n_mismatch, checks, n_gf, n_vf} = '0;
        seed = 32'h46560480;
        par = 1'b1;
        for (k = 0; k < 256; k++) mdl[k] = 8'h00;
        mdl[IDX_SEQ_LP] = RST_SEQ_LP;
        repeat (8) @(negedge ref_clk);
        resetn = 1'b1;
        rdc(IDX_SEQ_LP);
        rdc(IDX_HEIGHT_HI);
        rdc(IDX_HEIGHT_LO);
        for (k = 0; k < 4; k++) begin
            r = rnd();
            wr(IDX_HEIGHT_LO, r[7:0] & 8'hFE);
            wr(IDX_HEIGHT_HI, r[15:8] & 8'hC3);
            wr(IDX_F1_LO, r[23:16]);
            wr(IDX_F1_HI, r[31:24]);
            wr(IDX_F2_LO, r[15:8]);
            wr(8'h43, r[7:0]);
            rdc(IDX_HEIGHT_HI);
            rdc(IDX_F1_HI);
            rdc(8'h43);
            chk(panel_height, {mdl[IDX_HEIGHT_HI][1:0], mdl[IDX_HEIGHT_LO]});
            chk(fifo1_start_addr, {mdl[IDX_F1_HI], mdl[IDX_F1_LO]});
            chk(fifo2_start_low, mdl[IDX_F2_LO]);
        end
        for (k = 0; k < 4; k++) begin
            {virtual_refresh_enable, dstn_select} = k[1:0];
            repeat (2) @(negedge ref_clk);
            chk(dual_panel_split, k == 3);
        end
        wr(IDX_HEIGHT_HI, 8'h00);
        for (k = 0; k < 2; k++) begin
            wr(IDX_SEQ_LP, k[0] ? 8'h40 : 8'h00);
            hs();
            repeat (40) @(negedge ref_clk);
            chk(last_w, k[0] ? 32 : 16);
        end
        dstn_select = 1'b1;
        for (k = 0; k < 5; k++) begin
            virtual_refresh_enable = (k == 4);
            r = rnd();
            e = {2'b00, k[1:0], r[3:0]};
            wr(IDX_SEQ_LP, e);
            rdc(IDX_SEQ_LP);
            n0 = n_lp;
            repeat (2) begin
                vs();
                repeat (400) @(negedge ref_clk);
            end
            chk(n_lp - n0, (k == 4) ? 2 * e[3:0] : e[5:4] + e[3:0]);
        end
        {dstn_select, virtual_refresh_enable} = 2'b00;
        wr(IDX_HEIGHT_HI, 8'h04);
        n0 = n_lp;
        repeat (400) @(negedge ref_clk);
        c = n_lp - n0;
        chk(c >= 9 && c <= 11, 1);
        wr(IDX_HEIGHT_HI, 8'h00);
        repeat (40) @(negedge ref_clk);
        n0 = n_lp;
        repeat (200) @(negedge ref_clk);
        chk(n_lp, n0);
        for (k = 0; k < 4; k++) begin
            display_enable_in = k[0];
            repeat (2) @(negedge ref_clk);
            chk(panel_mux_out, k[0]);
        end
        wr(IDX_HEIGHT_HI, 8'h80);
        repeat (2) begin
            vs();
            chk(panel_mux_out, par);
        end
        wr(IDX_HEIGHT_HI, 8'h30);
        rdc(IDX_HEIGHT_HI);
        wr(IDX_HEIGHT_HI, 8'h00);
        rdc(IDX_HEIGHT_HI);
        {n0, c} = {n_gf, n_vf};
        vs();
        rdc(IDX_HEIGHT_HI);
        chk(n_gf - n0, 1);
        chk(n_vf - c, 1);
        wr(IDX_HEIGHT_HI, 8'h08);
        rdc(IDX_HEIGHT_HI);
        fp_req = 1'b1;
        repeat (8) @(negedge ref_clk);
        fp_req = 1'b0;
        mdl[IDX_HEIGHT_HI][3] = 1'b0;
        rdc(IDX_HEIGHT_HI);
        r = rnd();
        step_code = r[1:0];
        c = 4 << r[1:0];
        wr(IDX_SEQ_LP, 8'h80);
        power_on_req = 1'b1;
        repeat (c - 1) vs();
        chk(pwr, 4'h7);
        repeat (2) vs();
        chk(pwr, 4'hF);
        power_on_req = 1'b0;
        repeat (c - 1) vs();
        chk(pwr, 4'h1);
        repeat (2) vs();
        chk(pwr, 4'h0);
        wr(IDX_SEQ_LP, 8'h00);
        r = rnd();
        sw_power_ctrl = r[3:0];
        repeat (2) @(negedge ref_clk);
        chk(pwr, r[3:0]);
        end_of_test();
    end
endmodule
`default_nettype wire
